//--- pkg/gpio_port_defs.vh
// Constants for the shared eight-pin port: register offsets, field positions, reset values.
// Assumes a byte-wide register port with one-cycle read latency.
`ifndef GPIO_PORT_DEFS_VH
`define GPIO_PORT_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_PORT_PIN_DATA 3'h0
`define OFS_PORT_OUTPUT_LATCH 3'h1
`define OFS_PORT_DIRECTION 3'h2
`define OFS_SEGMENT_ENABLE 3'h3
`define OFS_PAD_CONFIG_ONE 3'h4

// ****************************************
// Field positions
// ****************************************
`define PAD_OTHER_D_PU_BIT 7
`define PAD_OTHER_E_PU_BIT 6
`define PAD_PORT_PU_BIT 5
`define PAD_RTC_SEL_HI_BIT 2
`define PAD_RTC_SEL_LO_BIT 1
`define PAD_WRITE_MASK 8'he6

// ****************************************
// Reset values
// ****************************************
`define RST_DIRECTION 8'hff
`define RST_LATCH 8'h00
`define RST_SEGMENT 8'h00
`define RST_PAD 8'h00

// ****************************************
// Timing
// ****************************************
`define SYNC_STAGES 2

`endif

//--- src/pin_sync.v
// Two-stage synchroniser for the eight port pin levels.
// Assumes the pins are asynchronous to CLOCK_I.
`timescale 1ns/1ps
module pin_sync (
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] async_i,
   output wire [7:0] sync_o
);
   reg [7:0] meta_q;
   reg [7:0] sync_q;

   // The first stage is read only by the second, so metastability cannot reach logic.
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= 8'h00;
         sync_q <= 8'h00;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule

//--- src/bidir_port_lcd_shared.v
// Eight-pin bidirectional port whose upper seven pins are shared with LCD segment drivers.
// Assumes a byte-wide register port on CLOCK_I and pins asynchronous to that clock.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "gpio_port_defs.vh"

// Contract
// - Eight-bit port with a direction register and an output latch register.
// - Direction bit 0 drives latch onto pin; 1 makes pin an input.
// - After any reset every pin is a digital input.
// - Pin zero has no segment; pins 1 to 7 each share one segment.
// - An enabled segment owns the pin and disables all port functions.
// - Pins 1-3 map to segments 33-35; pins 4-7 to 39,38,37,36.
// - Each pin has a weak pull-up; pad config bit 5 clear disables all.
// - A pin set as output always has its pull-up switched off.
// - After any reset all pull-ups of the port are disabled.
// - Without this port the pull-up control bit is absent and reads zero.
// - Segment enable holds segments 39..32; pad config bits 2:1 select rtc output.
module bidir_port_lcd_shared #(
   parameter PORT_PRESENT = 1
) (
   // Clock and reset
   input wire CLOCK_I,
   input wire SYS_RST_I,
   // Register port
   input wire [2:0] ADDR_I,
   input wire [7:0] WDATA_I,
   input wire WR_I,
   input wire RD_I,
   output reg [7:0] RDATA_O,
   // Port pins
   input wire [7:0] PIN_I,
   output reg [7:0] PIN_O,
   output reg [7:0] PIN_OE_O,
   output reg [7:0] PULLUP_EN_O,
   // LCD segment driver side
   input wire [7:0] LCD_SEG_I,
   output reg [7:0] SEG_SEL_O,
   output reg [1:0] RTC_OUTPUT_SEL_O,
   output reg [1:0] OTHER_PULLUP_O
);

   // ****************************************
   // Register state
   // ****************************************
   reg [7:0] port_output_latch_q;
   reg [7:0] port_direction_q;
   reg [7:0] segment_enable_32_39_q;
   reg [7:0] pad_config_one_q;
   wire [7:0] pin_level;
   wire [7:0] pin_seg_en;
   wire [7:0] pin_seg_val;
   wire port_pullup_enable;

   // Segment number of each pin, relative to segment 32, as a bit index of the enable register.
   function [2:0] seg_index;
      input [2:0] pin;
      begin
         case (pin)
            3'h1: seg_index = 3'h1;
            3'h2: seg_index = 3'h2;
            3'h3: seg_index = 3'h3;
            3'h4: seg_index = 3'h7;
            3'h5: seg_index = 3'h6;
            3'h6: seg_index = 3'h5;
            3'h7: seg_index = 3'h4;
            default: seg_index = 3'h0;
         endcase
      end
   endfunction

   // ****************************************
   // Pin synchroniser
   // ****************************************
   pin_sync u_pin_sync (
      .clk_i(CLOCK_I),
      .rst_i(SYS_RST_I),
      .async_i(PIN_I),
      .sync_o(pin_level)
   );

   // ****************************************
   // Segment mapping
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_map
         if (g == 0) begin : g_none
            assign pin_seg_en[g] = 1'b0;
            assign pin_seg_val[g] = 1'b0;
         end else begin : g_seg
            assign pin_seg_en[g] = segment_enable_32_39_q[seg_index(g)];
            assign pin_seg_val[g] = LCD_SEG_I[seg_index(g)];
         end
      end
   endgenerate

   assign port_pullup_enable = pad_config_one_q[`PAD_PORT_PU_BIT];

   // ****************************************
   // Access decode
   // ****************************************
   // One decode function serves every register write, so no two write offsets can ever disagree.
   function hit;
      input [2:0] addr;
      input [2:0] offset;
      begin
         hit = (addr == offset);
      end
   endfunction

   // Offsets 5 to 7 decode to nothing, so writes there are dropped.
   wire wr_pin_data;
   wire wr_latch;
   wire wr_direction;
   wire wr_segment;
   wire wr_pad;

   assign wr_pin_data = WR_I & hit(ADDR_I, `OFS_PORT_PIN_DATA);
   assign wr_latch = WR_I & hit(ADDR_I, `OFS_PORT_OUTPUT_LATCH);
   assign wr_direction = WR_I & hit(ADDR_I, `OFS_PORT_DIRECTION);
   assign wr_segment = WR_I & hit(ADDR_I, `OFS_SEGMENT_ENABLE);
   assign wr_pad = WR_I & hit(ADDR_I, `OFS_PAD_CONFIG_ONE);

   // ****************************************
   // Register next values
   // ****************************************
   reg [7:0] port_output_latch_d;
   reg [7:0] port_direction_d;
   reg [7:0] segment_enable_32_39_d;
   reg [7:0] pad_config_one_d;

   // A write to either the port data or the latch offset lands in the same latch.
   always @* begin
      port_output_latch_d = port_output_latch_q;
      if (wr_pin_data) begin
         port_output_latch_d = WDATA_I;
      end else if (wr_latch) begin
         port_output_latch_d = WDATA_I;
      end
   end

   always @* begin
      port_direction_d = port_direction_q;
      if (wr_direction) begin
         port_direction_d = WDATA_I;
      end
   end

   always @* begin
      segment_enable_32_39_d = segment_enable_32_39_q;
      if (wr_segment) begin
         segment_enable_32_39_d = WDATA_I;
      end
   end

   // Unused bits are held at zero so that reads see them as zero.
   always @* begin
      pad_config_one_d = pad_config_one_q;
      if (wr_pad) begin
         pad_config_one_d = WDATA_I & `PAD_WRITE_MASK;
         if (PORT_PRESENT == 0) begin
            pad_config_one_d[`PAD_PORT_PU_BIT] = 1'b0;
         end
      end
   end

   // ****************************************
   // Register state update
   // ****************************************
   // Each register has its own process so that every reset value is traced to one line.
   always @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         port_output_latch_q <= `RST_LATCH;
      end else begin
         port_output_latch_q <= port_output_latch_d;
      end
   end

   always @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         port_direction_q <= `RST_DIRECTION;
      end else begin
         port_direction_q <= port_direction_d;
      end
   end

   always @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         segment_enable_32_39_q <= `RST_SEGMENT;
      end else begin
         segment_enable_32_39_q <= segment_enable_32_39_d;
      end
   end

   always @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         pad_config_one_q <= `RST_PAD;
      end else begin
         pad_config_one_q <= pad_config_one_d;
      end
   end

   // ****************************************
   // Register reads
   // ****************************************
   reg [7:0] rdata_d;

   // Pins owned by a segment read as zero since the port input is disabled there.
   function [7:0] pin_read;
      input [7:0] level;
      input [7:0] owned;
      begin
         pin_read = level & ~owned;
      end
   endfunction

   // Read data is zero outside the read slot, so a stale byte is never taken for an answer.
   always @* begin
      rdata_d = 8'h00;
      if (RD_I) begin
         case (ADDR_I)
            `OFS_PORT_PIN_DATA: rdata_d = pin_read(pin_level, pin_seg_en);
            `OFS_PORT_OUTPUT_LATCH: rdata_d = port_output_latch_q;
            `OFS_PORT_DIRECTION: rdata_d = port_direction_q;
            `OFS_SEGMENT_ENABLE: rdata_d = segment_enable_32_39_q;
            `OFS_PAD_CONFIG_ONE: rdata_d = pad_config_one_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         RDATA_O <= 8'h00;
      end else begin
         RDATA_O <= rdata_d;
      end
   end

   // ****************************************
   // Pin drive
   // ****************************************
   reg [7:0] pin_o_d;
   reg [7:0] pin_oe_d;
   reg [7:0] pullup_en_d;
   reg [7:0] seg_sel_d;
   reg [1:0] rtc_output_sel_d;
   reg [1:0] other_pullup_d;

   // Drive value of one pin: the segment value while the segment owns it, the latch bit otherwise.
   function drive_bit;
      input owned;
      input seg_val;
      input latch;
      begin
         drive_bit = owned ? seg_val : latch;
      end
   endfunction

   // Pull-up of one pin: global enable set, pin an input, no segment on it.
   function pullup_bit;
      input enable;
      input dir;
      input owned;
      begin
         pullup_bit = enable & dir & ~owned;
      end
   endfunction

   integer k;

   // Pin zero sees no segment, so its drive and pull-up follow the port alone.
   always @* begin
      pin_o_d = 8'h00;
      pin_oe_d = 8'h00;
      pullup_en_d = 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
         pin_o_d[k] = drive_bit(pin_seg_en[k], pin_seg_val[k], port_output_latch_q[k]);
         pin_oe_d[k] = pin_seg_en[k] | ~port_direction_q[k];
         pullup_en_d[k] = pullup_bit(port_pullup_enable, port_direction_q[k], pin_seg_en[k]);
      end
   end

   always @* begin
      seg_sel_d = pin_seg_en;
      rtc_output_sel_d = {pad_config_one_q[`PAD_RTC_SEL_HI_BIT], pad_config_one_q[`PAD_RTC_SEL_LO_BIT]};
      other_pullup_d = {pad_config_one_q[`PAD_OTHER_D_PU_BIT], pad_config_one_q[`PAD_OTHER_E_PU_BIT]};
   end

   // ****************************************
   // Output registers
   // ****************************************
   // Outputs are registered, so pin changes trail a register write by one cycle.
   always @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         PIN_O <= 8'h00;
      end else begin
         PIN_O <= pin_o_d;
      end
   end

   always @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         PIN_OE_O <= 8'h00;
      end else begin
         PIN_OE_O <= pin_oe_d;
      end
   end

   always @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         PULLUP_EN_O <= 8'h00;
      end else begin
         PULLUP_EN_O <= pullup_en_d;
      end
   end

   always @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         SEG_SEL_O <= 8'h00;
      end else begin
         SEG_SEL_O <= seg_sel_d;
      end
   end

   always @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         RTC_OUTPUT_SEL_O <= 2'h0;
      end else begin
         RTC_OUTPUT_SEL_O <= rtc_output_sel_d;
      end
   end

   always @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         OTHER_PULLUP_O <= 2'h0;
      end else begin
         OTHER_PULLUP_O <= other_pullup_d;
      end
   end

endmodule

//--- verification/pin_pad_model.sv
// Pad model: resolves each port pin from the block's drive, the pull-ups and an outside driver.
// Assumes the bench sets the outside driver and its enables.
`timescale 1ns/1ps
module pin_pad_model (
   input wire clk_i,
   input wire [7:0] drive_i,
   input wire [7:0] oe_i,
   input wire [7:0] pullup_i,
   input wire [7:0] ext_i,
   input wire [7:0] ext_en_i,
   output wire [7:0] pin_o
);
   // A floating pin toggles, so a read of an undriven pin never passes by luck.
   reg [7:0] float_q = 8'h55;
   always @(posedge clk_i) begin
      float_q <= ~float_q;
   end
   assign pin_o = (oe_i & drive_i) | (~oe_i & ext_en_i & ext_i) | (~oe_i & ~ext_en_i & (pullup_i | float_q));
endmodule

//--- verification/bidir_port_lcd_shared_assertions.sv
// Checker for the shared eight-pin port.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module bidir_port_lcd_shared_assertions (
   input wire CLOCK_I,
   input wire SYS_RST_I,
   input wire [2:0] ADDR_I,
   input wire [7:0] WDATA_I,
   input wire WR_I,
   input wire RD_I,
   input wire [7:0] RDATA_O,
   input wire [7:0] PIN_OE_O,
   input wire [7:0] PULLUP_EN_O,
   input wire [7:0] SEG_SEL_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (SYS_RST_I);
   a_reset_pins_idle:
      assert property ($fell(SYS_RST_I) |-> PIN_OE_O == 8'h00 && PULLUP_EN_O == 8'h00) else $error("Pins busy after reset.");
   a_pin_zero_plain:
      assert property (SEG_SEL_O[0] == 1'b0) else $error("Pin zero owned by a segment.");
   a_segment_owns_pin:
      assert property ((SEG_SEL_O & ~PIN_OE_O) == 8'h00) else $error("Segment pin not driven.");
   a_segment_no_pullup:
      assert property ((SEG_SEL_O & PULLUP_EN_O) == 8'h00) else $error("Pull-up on segment pin.");
   a_output_no_pullup:
      assert property ((PIN_OE_O & PULLUP_EN_O) == 8'h00) else $error("Pull-up on output pin.");
   a_read_data_idle:
      assert property (!$past(RD_I) |-> RDATA_O == 8'h00) else $error("Read data outside read slot.");
   a_unmapped_read_zero:
      assert property ($past(RD_I) && $past(ADDR_I) > 3'h4 |-> RDATA_O == 8'h00) else $error("Unmapped read not zero.");
   a_direction_to_pins:
      assert property (WR_I && ADDR_I == 3'h2 ##1 !(WR_I && ADDR_I == 3'h2) |=>
         (PIN_OE_O & ~SEG_SEL_O) == (~$past(WDATA_I, 2) & ~SEG_SEL_O)) else $error("Direction not applied.");
endmodule
bind bidir_port_lcd_shared bidir_port_lcd_shared_assertions i_bidir_port_lcd_shared_assertions (.*);

//--- verification/bidir_port_lcd_shared_tb.sv
// Bench for the shared eight-pin port.
// Assumes the pad model and the bound checker.
`timescale 1ns/1ps
module bidir_port_lcd_shared_tb;
   reg clk = 0, rst = 1, wr = 0, rd = 0;
   reg [2:0] addr = 3'h0;
   reg [7:0] wdata = 8'h00, lcd = 8'ha5, ext = 8'h00, ext_en = 8'h00;
   wire [7:0] rdata, pin_in, pin_out, oe, pu, sel;
   wire [1:0] rtc, opu;
   integer n_errors = 0, checked = 0, i;
   logic [7:0] exp_sel [8] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h80, 8'h40, 8'h20, 8'h10};
   always #5 clk = ~clk;
   bidir_port_lcd_shared i_bidir_port_lcd_shared (.CLOCK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PIN_I(pin_in), .PIN_O(pin_out), .PIN_OE_O(oe), .PULLUP_EN_O(pu),
      .LCD_SEG_I(lcd), .SEG_SEL_O(sel), .RTC_OUTPUT_SEL_O(rtc), .OTHER_PULLUP_O(opu));
   pin_pad_model i_pin_pad_model (.clk_i(clk), .drive_i(pin_out), .oe_i(oe), .pullup_i(pu), .ext_i(ext),
      .ext_en_i(ext_en), .pin_o(pin_in));
   task chk(input logic [7:0] s, input logic [7:0] e);
      begin
         checked = checked + 1;
         if (s !== e) begin
            n_errors = n_errors + 1;
            $display("Error %0t seen %h expected %h", $time, s, e);
         end
      end
   endtask
   task wr_reg(input logic [2:0] a, input logic [7:0] d);
      begin
         @(posedge clk);
         wr <= 1'b1;
         addr <= a;
         wdata <= d;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rd_reg(input logic [2:0] a, input logic [7:0] e);
      begin
         @(posedge clk);
         rd <= 1'b1;
         addr <= a;
         @(posedge clk);
         rd <= 1'b0;
         #1 chk(rdata, e);
      end
   endtask
   // Outputs settle two edges after a write, pin reads need the two-flop synchroniser too.
   task idle(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task final_report;
      begin
         if (n_errors == 0 && checked > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      #100000;
      n_errors = n_errors + 1;
      final_report;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd_reg(3'h2, 8'hff);
      rd_reg(3'h4, 8'h00);
      chk(oe, 8'h00);
      wr_reg(3'h4, 8'hff);
      rd_reg(3'h4, 8'he6);
      idle(2);
      chk(pu, 8'hff);
      chk({6'h00, rtc}, 8'h03);
      chk({6'h00, opu}, 8'h03);
      idle(4);
      rd_reg(3'h0, 8'hff);
      @(posedge clk);
      ext <= 8'h5a;
      ext_en <= 8'hff;
      idle(4);
      rd_reg(3'h0, 8'h5a);
      wr_reg(3'h0, 8'h3c);
      rd_reg(3'h1, 8'h3c);
      wr_reg(3'h2, 8'hcf);
      idle(2);
      chk(oe & pin_out, 8'h30);
      chk(pu, 8'hcf);
      idle(4);
      rd_reg(3'h0, 8'h7a);
      for (i = 0; i < 8; i = i + 1) begin
         wr_reg(3'h3, 8'h01 << i);
         idle(2);
         chk(sel, exp_sel[i]);
      end
      chk({7'h00, pin_out[4]}, {7'h00, lcd[7]});
      idle(4);
      rd_reg(3'h0, 8'h6a);
      wr_reg(3'h4, 8'h00);
      idle(2);
      chk(pu, 8'h00);
      chk({6'h00, rtc}, 8'h00);
      wr_reg(3'h5, 8'hff);
      rd_reg(3'h5, 8'h00);
      rd_reg(3'h1, 8'h3c);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_reg(3'h2, 8'hff);
      chk(pu, 8'h00);
      final_report;
   end
endmodule
